// ### rtl/dwt_pkg.sv
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package dwt_pkg;

    // -----------------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------------
    localparam logic [7:0] DWT_ADDR_WATCHDOG = 8'hd8;
    localparam logic [7:0] DWT_RESET_VALUE   = 8'hfe;

    // Field positions inside the watchdog register
    localparam int DWT_BIT_ARM        = 0;
    localparam int DWT_BIT_SELF_RESET = 1;
    localparam int DWT_BIT_PERIOD_MSB = 2;
    localparam int DWT_BIT_PERIOD_LSB = 7;

    // -----------------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------------
    localparam int          DWT_PRESCALE_CYCLES = 3072;
    localparam logic [11:0] DWT_PRESCALE_LAST   = 12'(DWT_PRESCALE_CYCLES - 1);
    localparam logic [6:0]  DWT_COUNT_RESET     = 7'h7f;
    localparam int          DWT_RESET_PULSE     = 1;

    // Core power state handed to the rest of the chip
    typedef enum logic [1:0] {
        DWT_PWR_RUN  = 2'b00,
        DWT_PWR_WAIT = 2'b01,
        DWT_PWR_STOP = 2'b10
    } dwt_pwr_t;

endpackage : dwt_pkg

// ### rtl/dwt_tick_if.sv
`timescale 1ns/100ps
// Prescaler link between the watchdog core and its tick generator
interface dwt_tick_if;
    logic run;
    logic restart;
    logic tick;

    modport core (output run, output restart, input tick);
    modport gen  (input run, input restart, output tick);
endinterface : dwt_tick_if

// ### rtl/dwt_prescaler.sv
`timescale 1ns/100ps
// Divides the system clock down to one counter step per period unit
module dwt_prescaler (
    // Clock and reset
    input  wire logic  sys_clk,
    input  wire logic  rst_n,
    // Core side
    dwt_tick_if.gen    tk
);
    typedef struct packed {
        logic [11:0] cnt;
    } dwt_pre_state_t;

    dwt_pre_state_t st_r;
    dwt_pre_state_t st_nxt;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    // Restart aligns the first step to a full prescale after a reload
    always_comb begin
        st_nxt = st_r;
        if (tk.restart || !tk.run) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt == dwt_pkg::DWT_PRESCALE_LAST) begin
            st_nxt.cnt = '0;
        end else begin
            st_nxt.cnt = st_r.cnt + 12'h001;
        end
    end

    assign tk.tick = tk.run && !tk.restart && (st_r.cnt == dwt_pkg::DWT_PRESCALE_LAST);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : dwt_prescaler

// ### rtl/dwt_watchdog.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Digital watchdog: reloadable down counter with self reset
// ---------------------------------------------------------------------------
module dwt_watchdog (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Mask options, static straps
    input  wire logic        opt_hw_activation,
    input  wire logic        opt_ext_stop_ctrl,
    // Core power requests
    input  wire logic        stop_exec,
    input  wire logic        wake_irq,
    input  wire logic        nmi_pin,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Status towards the chip
    output logic             wdt_reset_req,
    output logic             wdt_active,
    output logic             osc_halt,
    output dwt_pkg::dwt_pwr_t pwr_state
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]        nmi_sync;   // Pin synchroniser, bit 0 first stage
        logic              armed;
        logic [6:0]        count;      // Bit 6 is the self-reset stage
        dwt_pkg::dwt_pwr_t pwr;
        logic              rst_req;
        logic [7:0]        rdata;
    } dwt_state_t;

    dwt_state_t st_r;
    dwt_state_t st_nxt;

    dwt_tick_if tk ();

    logic active;
    logic wr_hit;
    logic frozen;

    // ------------------------------------------------------------------
    // Bit reversal between register and counter
    // ------------------------------------------------------------------
    // Register bit 7 is counter bit 0, register bit 2 is counter bit 5
    function automatic logic [5:0] dwt_rev6(input logic [5:0] v);
        logic [5:0] r;
        r = '0;
        for (int i = 0; i < 6; i++) begin
            r[i] = v[5 - i];
        end
        return r;
    endfunction : dwt_rev6

    // Register image of a counter value and arming flag
    function automatic logic [7:0] dwt_image(input logic [6:0] c, input logic a);
        return {dwt_rev6(c[5:0]), c[6], a};
    endfunction : dwt_image

    // ------------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------------
    assign active = opt_hw_activation || st_r.armed;
    assign wr_hit = reg_wr && (reg_addr == dwt_pkg::DWT_ADDR_WATCHDOG);
    assign frozen = (st_r.pwr == dwt_pkg::DWT_PWR_STOP);

    // Counter runs in run and wait; stop freezes it in every mode
    assign tk.run     = !frozen;
    assign tk.restart = wr_hit;

    dwt_prescaler u_pre (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .tk      (tk)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt          = st_r;
        st_nxt.nmi_sync = {st_r.nmi_sync[0], nmi_pin};
        st_nxt.rst_req  = 1'b0;

        // Counter: reload on write, else step on prescaler tick
        if (wr_hit) begin
            st_nxt.count = {reg_wdata[dwt_pkg::DWT_BIT_SELF_RESET],
                            dwt_rev6(reg_wdata[dwt_pkg::DWT_BIT_PERIOD_LSB:
                                               dwt_pkg::DWT_BIT_PERIOD_MSB])};
            if (reg_wdata[dwt_pkg::DWT_BIT_ARM]) begin
                st_nxt.armed = 1'b1;
            end
            // A zero never clears the arming flag
            if (!reg_wdata[dwt_pkg::DWT_BIT_SELF_RESET]) begin
                st_nxt.rst_req = 1'b1;
            end
        end else if (tk.tick) begin
            st_nxt.count = st_r.count - 7'h01;
            // Bit 6 falling ends the period when active
            if (active && st_r.count[6] && !st_nxt.count[6]) begin
                st_nxt.rst_req = 1'b1;
            end
        end

        // Power state: stop only truly stops where the watchdog allows it
        case (st_r.pwr)
            dwt_pkg::DWT_PWR_RUN: begin
                if (stop_exec) begin
                    if (!active) begin
                        st_nxt.pwr = dwt_pkg::DWT_PWR_STOP;
                    end else if (!opt_ext_stop_ctrl) begin
                        st_nxt.pwr = dwt_pkg::DWT_PWR_WAIT;
                    end else if (st_r.nmi_sync[1]) begin
                        st_nxt.pwr = dwt_pkg::DWT_PWR_STOP;
                    end else begin
                        st_nxt.pwr = dwt_pkg::DWT_PWR_WAIT;
                    end
                end
            end
            dwt_pkg::DWT_PWR_WAIT,
            dwt_pkg::DWT_PWR_STOP: begin
                if (wake_irq) begin
                    st_nxt.pwr = dwt_pkg::DWT_PWR_RUN;
                end
            end
            default: begin
                st_nxt.pwr = dwt_pkg::DWT_PWR_RUN;
            end
        endcase

        // Read data stands for the one cycle after the strobe
        if (reg_rd && reg_addr == dwt_pkg::DWT_ADDR_WATCHDOG) begin
            st_nxt.rdata = dwt_image(st_r.count, active);
        end else begin
            st_nxt.rdata = 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Chip reset (which this block itself requests) restores all state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.nmi_sync <= 2'b00;
            st_r.armed    <= 1'b0;
            st_r.count    <= dwt_pkg::DWT_COUNT_RESET;
            st_r.pwr      <= dwt_pkg::DWT_PWR_RUN;
            st_r.rst_req  <= 1'b0;
            st_r.rdata    <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata     = st_r.rdata;
    assign wdt_reset_req = st_r.rst_req;
    assign wdt_active    = active;
    assign osc_halt      = frozen;
    assign pwr_state     = st_r.pwr;

endmodule : dwt_watchdog

// ### verif/dwt_watchdog_asserts.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Port checker for the watchdog
// ---------------------------------------------------------------------------
module dwt_watchdog_asserts (
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              rst_n,
    // Options and requests
    input wire logic              opt_hw_activation,
    input wire logic              opt_ext_stop_ctrl,
    input wire logic              stop_exec,
    input wire logic [7:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    // Outputs
    input wire logic [7:0]        reg_rdata,
    input wire logic              wdt_reset_req,
    input wire logic              wdt_active,
    input wire logic              osc_halt,
    input wire dwt_pkg::dwt_pwr_t pwr_state
);
    logic wsel;
    logic run_stop;
    // Decoded write and stop request from run
    assign wsel     = reg_wr && reg_addr == 8'hd8;
    assign run_stop = stop_exec && pwr_state == dwt_pkg::DWT_PWR_RUN;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sr_clear_a: assert property (wsel && !reg_wdata[1] |=> wdt_reset_req)
        else $error("self reset write gave no reset");
    arm_sticky_a: assert property (wdt_active |=> wdt_active)
        else $error("watchdog disarmed");
    hw_active_a: assert property (opt_hw_activation |-> wdt_active)
        else $error("hardware option inactive");
    sw_idle_a: assert property (!opt_hw_activation && !wdt_active && !(wsel && reg_wdata[0])
        |=> !wdt_active)
        else $error("armed without write");
    arm_set_a: assert property (wsel && reg_wdata[0] |=> wdt_active)
        else $error("arming write ignored");
    idle_quiet_a: assert property (!wdt_active && !(wsel && !reg_wdata[1])
        |=> !wdt_reset_req)
        else $error("reset while unarmed");
    true_stop_a: assert property (run_stop && !wdt_active
        |=> pwr_state == dwt_pkg::DWT_PWR_STOP && osc_halt)
        else $error("inactive stop not entered");
    hw_wait_a: assert property (run_stop && opt_hw_activation && !opt_ext_stop_ctrl
        |=> pwr_state == dwt_pkg::DWT_PWR_WAIT && !osc_halt)
        else $error("stop not turned into wait");
    hw_arm_rd_a: assert property (reg_rd && reg_addr == 8'hd8 && opt_hw_activation
        |=> reg_rdata[0])
        else $error("arming bit read low");

    // Main scenarios reached
    cover property (wdt_reset_req);
    cover property (pwr_state == dwt_pkg::DWT_PWR_STOP);
    cover property (run_stop && opt_ext_stop_ctrl);
endmodule : dwt_watchdog_asserts

bind dwt_watchdog dwt_watchdog_asserts chk_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .opt_hw_activation(opt_hw_activation),
    .opt_ext_stop_ctrl(opt_ext_stop_ctrl), .stop_exec(stop_exec), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wdt_reset_req(wdt_reset_req), .wdt_active(wdt_active), .osc_halt(osc_halt),
    .pwr_state(pwr_state));

// ### verif/tb_digital_watchdog_timer.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Watchdog testbench
// ---------------------------------------------------------------------------
module tb_digital_watchdog_timer;
    logic sys_clk, rst_n, opt_hw, opt_ext, stop_exec, wake_irq, nmi_pin;
    logic reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic wdt_reset_req, wdt_active, osc_halt;
    dwt_pkg::dwt_pwr_t pwr_state;
    logic [31:0] seed;
    int err_total, samples_checked, n;

    dwt_watchdog dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .opt_hw_activation(opt_hw),
        .opt_ext_stop_ctrl(opt_ext), .stop_exec(stop_exec), .wake_irq(wake_irq),
        .nmi_pin(nmi_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wdt_reset_req(wdt_reset_req),
        .wdt_active(wdt_active), .osc_halt(osc_halt), .pwr_state(pwr_state));

    // Image of counter and arming bit as software reads it, bits reversed
    function automatic logic [7:0] img(input logic [6:0] c, input logic a);
        return {c[0], c[1], c[2], c[3], c[4], c[5], c[6], a};
    endfunction : img

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rc

    // Options are straps, so they only change under reset
    task automatic rs(input logic hw, input logic ex);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        opt_hw <= hw;
        opt_ext <= ex;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask : rs

    task automatic ps(input logic w, input dwt_pkg::dwt_pwr_t e);
        @(posedge sys_clk);
        if (w) wake_irq <= 1'b1;
        else stop_exec <= 1'b1;
        @(posedge sys_clk);
        wake_irq <= 1'b0;
        stop_exec <= 1'b0;
        #1 chk(pwr_state, e);
    endtask : ps

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Whole run is about 10k cycles; give it twice that
    initial begin
        #2000000;
        err_total++;
        end_sim();
    end

    initial begin
        {rst_n, opt_hw, opt_ext, stop_exec, wake_irq, nmi_pin, reg_wr, reg_rd} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        err_total = 0;
        samples_checked = 0;
        seed = 32'h23f3249b;
        rs(1'b0, 1'b0);
        rc(8'hd8, 8'hfe);
        // Random periods, self reset kept set, arming clear
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            d = {seed[7:2], 2'b10};
            wr(8'hd8, d);
            rc(8'hd8, d);
            chk(wdt_active, 1'b0);
            rc({seed[15:9], 1'b1}, 8'h00);
        end
        $display("register test done");
        // Armed with counter 0x40: one step drops bit 6
        wr(8'hd8, 8'h03);
        wr(8'hd8, 8'h02);
        #1 chk(wdt_active, 1'b1);
        n = 0;
        while (wdt_reset_req !== 1'b1 && n < 4000) begin
            @(posedge sys_clk);
            #1 n++;
        end
        chk(n >= 3068 && n <= 3078, 1'b1);
        $display("timeout test done");
        rs(1'b0, 1'b0);
        wr(8'hd8, 8'hfc);
        #1 chk(wdt_reset_req, 1'b1);
        rs(1'b0, 1'b0);
        ps(1'b0, dwt_pkg::DWT_PWR_STOP);
        chk(osc_halt, 1'b1);
        ps(1'b1, dwt_pkg::DWT_PWR_RUN);
        rs(1'b1, 1'b0);
        wr(8'hd8, 8'hfe);
        rc(8'hd8, 8'hff);
        ps(1'b0, dwt_pkg::DWT_PWR_WAIT);
        ps(1'b1, dwt_pkg::DWT_PWR_RUN);
        $display("option test done");
        rs(1'b1, 1'b1);
        ps(1'b0, dwt_pkg::DWT_PWR_WAIT);
        ps(1'b1, dwt_pkg::DWT_PWR_RUN);
        nmi_pin <= 1'b1;
        repeat (3) @(posedge sys_clk);
        ps(1'b0, dwt_pkg::DWT_PWR_STOP);
        repeat (3300) @(posedge sys_clk);
        rc(8'hd8, img(7'h7f, 1'b1));
        ps(1'b1, dwt_pkg::DWT_PWR_RUN);
        repeat (3100) @(posedge sys_clk);
        rc(8'hd8, img(7'h7e, 1'b1));
        $display("stop test done");
        end_sim();
    end
endmodule : tb_digital_watchdog_timer
